// File: rtl/slm_pkg.sv
// shared constants, types and decoders for the serial lane mapper
package slm_pkg;
    // geometry
    localparam int SLM_LANES  = 8;
    localparam int SLM_CHANS  = 4;
    localparam int SLM_SPC    = 16;  // samples per channel held per frame
    localparam int SLM_SMP_W  = 12;
    localparam int SLM_WORD_W = 40;  // widest lane frame, five octets
    localparam int SLM_PD_SYNC = 3;  // flip-flops on the power-down pin

    // register byte offsets
    localparam logic [7:0] SLM_REG_CTRL   = 8'h00;
    localparam logic [7:0] SLM_REG_STATUS = 8'h04;
    localparam logic [7:0] SLM_REG_FRAMES = 8'h08;

    // control field positions
    localparam int SLM_CTRL_LINK_EN = 0;
    localparam int SLM_CTRL_PD      = 1;
    localparam int SLM_CTRL_FEC     = 2;
    localparam int SLM_CTRL_ALT     = 3;
    localparam int SLM_CTRL_PAIR    = 4;   // two bits
    localparam int SLM_CTRL_MODE    = 8;   // five bits
    localparam int SLM_CTRL_TEST    = 16;  // three bits

    // values after reset
    localparam logic [1:0] SLM_PAIR_RST = 2'h3;
    localparam logic [4:0] SLM_MODE_RST = 5'h0E;

    // link modes
    localparam logic [4:0] SLM_MODE_8B   = 5'h0C;
    localparam logic [4:0] SLM_MODE_10B  = 5'h0D;
    localparam logic [4:0] SLM_MODE_12B2 = 5'h0E;
    localparam logic [4:0] SLM_MODE_12B  = 5'h0F;

    // prbs start state, lane number plus one is or-ed into the low bits
    localparam logic [30:0] SLM_PRBS_SEED = 31'h2B5A_6C00;

    typedef enum logic [2:0] {
        TST_NONE   = 3'h0,
        TST_PRBS7  = 3'h1,
        TST_PRBS9  = 3'h2,
        TST_PRBS15 = 3'h3,
        TST_PRBS23 = 3'h4,
        TST_PRBS31 = 3'h5
    } slm_test_t;

    typedef struct packed {
        logic [SLM_CHANS-1:0][SLM_SPC-1:0][SLM_SMP_W-1:0] smp;
    } slm_frame_t;

    typedef struct packed {
        logic [SLM_LANES-1:0][SLM_WORD_W-1:0] data;
        logic                                 valid;
        logic [SLM_LANES-1:0]                 drv_en;
        logic                                 bypass;
        logic                                 enc_64b66b;
        logic                                 fec;
        logic [2:0]                           octets;
    } slm_lane_t;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } slm_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } slm_apb_rsp_t;

    // register length of each prbs
    function automatic int slm_prbs_len(input slm_test_t t);
        case (t)
            TST_PRBS9:  return 9;
            TST_PRBS15: return 15;
            TST_PRBS23: return 23;
            TST_PRBS31: return 31;
            default:    return 7;
        endcase
    endfunction

    // shorter tap of each prbs
    function automatic int slm_prbs_tap(input slm_test_t t);
        case (t)
            TST_PRBS9:  return 5;
            TST_PRBS15: return 14;
            TST_PRBS23: return 18;
            TST_PRBS31: return 28;
            default:    return 6;
        endcase
    endfunction
endpackage

// File: rtl/slm_fifo.sv
// frame fifo with registered read data
`timescale 1ns/10ps
module slm_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rstn,
    // fill side
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_valid,
    output logic              o_ready,
    // drain side
    output logic [W-1:0]      o_data,
    output logic              o_valid,
    input  wire logic         i_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
        logic          full;
        logic          ready;
        logic          ovalid;
    } slm_fifo_st_t;

    slm_fifo_st_t st;
    slm_fifo_st_t next_st;
    logic [W-1:0] mem [DEPTH];
    logic [W-1:0] rdata;
    logic         push;
    logic         pop;

    // ready is a flop of its own so upstream sees no logic; it stays low in the cycle after reset
    assign push    = i_valid && st.ready;
    assign pop     = (st.count != '0) && (!st.ovalid || i_ready);
    assign o_ready = st.ready;
    assign o_valid = st.ovalid;
    assign o_data  = rdata;

    // pointer and count update
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wptr = (st.wptr == AW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = (st.rptr == AW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
        end
        next_st.count  = st.count + (AW+1)'(push) - (AW+1)'(pop);
        next_st.full   = (next_st.count == (AW+1)'(DEPTH));
        next_st.ready  = !next_st.full;
        next_st.ovalid = pop || (st.ovalid && !i_ready);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // storage; pop never reads a slot written in the same cycle
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[st.wptr] <= i_data;
        end
        if (pop) begin
            rdata <= mem[st.rptr];
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    a_fifo_no_overrun: assert property (st.full |-> !push)
        else $error("fifo accepted a word while full");
    a_fifo_full_ready: assert property ((st.count == (AW+1)'(DEPTH)) |-> !o_ready)
        else $error("fifo full but ready high");
endmodule // slm_fifo

// File: rtl/slm_lane_map.sv
// lane mapper: link-mode packing, alternate lanes, power-down and prbs test patterns
//
// Contract
// - mode 12: one octet, lane k sample k
// - mode 13: four 10-bit samples, stride four
// - mode 14: lane pair per channel, even/odd samples
// - mode 15: lane carries samples k and k+4
// - only crc-12 on the sync header
// - fec as alternative sync header use
// - alternate lanes only with four lanes or fewer
// - select 0 lower lanes, 1 upper lanes
// - power-down disables the lane drivers
// - configuration retained through power-down
// - channel pairs powered down by pair enable
// - lane count follows link mode in tests
// - prbs bypasses transport and link layers
// - prbs start phase differs per lane
// - prbs7, prbs9, prbs15 by two-tap xor
// - prbs23 and prbs31 taps likewise
`timescale 1ns/10ps
module slm_lane_map #(
    parameter int NUM_CH     = 4,
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rstn,
    // register bus
    input  wire slm_pkg::slm_apb_req_t i_apb,
    output slm_pkg::slm_apb_rsp_t      o_apb,
    // power-down pin
    input  wire logic                  i_power_down_pin,
    // converter frames in
    input  wire slm_pkg::slm_frame_t   i_frame,
    input  wire logic                  i_frame_valid,
    output logic                       o_frame_ready,
    // lanes out
    output slm_pkg::slm_lane_t         o_lane
);
    import slm_pkg::*;

    typedef enum logic {
        AP_IDLE = 1'b0,
        AP_ANS  = 1'b1
    } slm_ap_t;

    typedef struct packed {
        logic [SLM_PD_SYNC-1:0]              pd_sync;
        logic                                pd_pin;
        logic                                link_en;
        logic                                pd_req;
        logic                                fec;
        logic                                alt_sel;
        logic [1:0]                          pair_en;
        logic [4:0]                          mode;
        logic [2:0]                          test_req;
        slm_test_t                           test;
        slm_ap_t                             ap;
        slm_apb_rsp_t                        rsp;
        logic [SLM_LANES-1:0][30:0]          prbs;
        slm_lane_t                           lane;
        logic [31:0]                         frames;
    } slm_state_t;

    localparam slm_state_t ST_RST = '{pair_en: SLM_PAIR_RST, mode: SLM_MODE_RST,
                                      test: TST_NONE, ap: AP_IDLE, default: '0};

    slm_state_t st;
    slm_state_t next_st;
    slm_frame_t fifo_data;
    logic       fifo_valid;
    logic       fifo_take;
    logic       fifo_ready;

    // lanes a link mode powers up, from the channel count of this part
    function automatic logic [3:0] lanes_for(input logic [4:0] mode);
        case (mode)
            SLM_MODE_8B, SLM_MODE_10B, SLM_MODE_12B: return (NUM_CH >= 2) ? 4'h8 : 4'h4;
            SLM_MODE_12B2:                           return 4'(2 * NUM_CH);
            default:                                 return 4'h0;
        endcase
    endfunction

    // octets per lane frame
    function automatic logic [2:0] octets_for(input logic [4:0] mode);
        case (mode)
            SLM_MODE_8B:                 return 3'h1;
            SLM_MODE_10B:                return 3'h5;
            SLM_MODE_12B2, SLM_MODE_12B: return 3'h3;
            default:                     return 3'h0;
        endcase
    endfunction

    // test select decode; reserved codes act as no test
    function automatic slm_test_t test_decode(input logic [2:0] v);
        return (v >= 3'h1 && v <= 3'h5) ? slm_test_t'(v) : TST_NONE;
    endfunction

    // forty bits of prbs, first bit on the line in bit 39
    function automatic logic [70:0] prbs_run(input logic [30:0] seed_in, input slm_test_t t);
        logic [30:0] s;
        logic [39:0] b;
        logic        nb;
        int          ta;
        int          tb;
        s  = seed_in;
        b  = '0;
        ta = slm_prbs_tap(t);
        tb = slm_prbs_len(t);
        for (int i = 0; i < SLM_WORD_W; i++) begin
            nb        = s[ta-1] ^ s[tb-1];
            b[39 - i] = nb;
            s         = {s[29:0], nb};
        end
        return {s, b};
    endfunction

    // pack one frame of samples onto the logical lanes
    function automatic logic [SLM_LANES-1:0][SLM_WORD_W-1:0] map_frame(input slm_frame_t f,
                                                                     input logic [4:0] mode);
        logic [SLM_LANES-1:0][SLM_WORD_W-1:0] w;
        int                                   ch;
        int                                   k;
        w = '0;
        for (int l = 0; l < SLM_LANES; l++) begin
            ch = l / 4;
            k  = l % 4;
            case (mode)
                SLM_MODE_8B: begin
                    w[l][39:32] = f.smp[ch][k][11:4];
                end
                SLM_MODE_10B: begin
                    w[l] = {f.smp[ch][k][11:2], f.smp[ch][k+4][11:2],
                            f.smp[ch][k+8][11:2], f.smp[ch][k+12][11:2]};
                end
                SLM_MODE_12B2: begin
                    w[l][39:16] = {f.smp[l/2][l%2], f.smp[l/2][(l%2)+2]};
                end
                SLM_MODE_12B: begin
                    w[l][39:16] = {f.smp[ch][k], f.smp[ch][k+4]};
                end
                default: begin
                    w[l] = '0;
                end
            endcase
        end
        return w;
    endfunction

    // frames wait here while the link is down or a test runs
    slm_fifo #(
        .W     ($bits(slm_frame_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk (i_ref_clk),
        .i_rstn    (i_rstn),
        .i_data    (i_frame),
        .i_valid   (i_frame_valid),
        .o_ready   (fifo_ready),
        .o_data    (fifo_data),
        .o_valid   (fifo_valid),
        .i_ready   (fifo_take)
    );

    // drain only in normal data mode with a live, powered link
    assign fifo_take     = st.link_en && !(st.pd_pin || st.pd_req) && (st.test == TST_NONE)
                           && (lanes_for(st.mode) != 4'h0);
    assign o_frame_ready = fifo_ready;
    assign o_apb         = st.rsp;
    assign o_lane        = st.lane;

    // next state
    always_comb begin
        logic                                 pd_act;
        logic [3:0]                           nlanes;
        logic                                 alt_act;
        logic [SLM_LANES-1:0]                 en;
        logic                                 gate_hi;
        logic [SLM_LANES-1:0][SLM_WORD_W-1:0] words;
        logic [30:0]                          s;
        logic [30:0]                          mask;
        logic [70:0]                          run;
        logic                                 mapped;
        logic                                 prbs_on;
        pd_act  = 1'b0;
        nlanes  = '0;
        alt_act = 1'b0;
        en      = '0;
        gate_hi = 1'b0;
        words   = '0;
        s       = '0;
        mask    = '0;
        run     = '0;
        mapped  = 1'b0;
        prbs_on = 1'b0;
        next_st = st;

        // pin filter: stage 0 feeds only stage 1; a level counts once stages 1 and 2 agree
        next_st.pd_sync = {st.pd_sync[SLM_PD_SYNC-2:0], i_power_down_pin};
        if (st.pd_sync[1] == st.pd_sync[2]) begin
            next_st.pd_pin = st.pd_sync[2];
        end
        pd_act = st.pd_pin || st.pd_req;

        // apb slave: one wait state, write lands at the edge that sees pready
        mapped = (i_apb.paddr == SLM_REG_CTRL) || (i_apb.paddr == SLM_REG_STATUS)
                 || (i_apb.paddr == SLM_REG_FRAMES);
        next_st.rsp.pready = 1'b0;
        unique case (st.ap)
            AP_IDLE: begin
                if (i_apb.psel && i_apb.penable) begin
                    next_st.ap          = AP_ANS;
                    next_st.rsp.pready  = 1'b1;
                    next_st.rsp.pslverr = !mapped;
                    next_st.rsp.prdata  = '0;
                    if (!i_apb.pwrite) begin
                        case (i_apb.paddr)
                            SLM_REG_CTRL: begin
                                next_st.rsp.prdata = {13'h0, st.test_req, 3'h0, st.mode, 2'h0,
                                                      st.pair_en, st.alt_sel, st.fec, st.pd_req,
                                                      st.link_en};
                            end
                            SLM_REG_STATUS: begin
                                nlanes = lanes_for(st.mode);
                                next_st.rsp.prdata = {13'h0, st.test, 7'h0, fifo_valid,
                                                      nlanes, st.alt_sel && (nlanes > 4'h4),
                                                      nlanes == 4'h0, |st.lane.drv_en[7:4]
                                                      && !(|st.lane.drv_en[3:0]), pd_act};
                            end
                            SLM_REG_FRAMES: begin
                                next_st.rsp.prdata = st.frames;
                            end
                            default: begin
                                next_st.rsp.prdata = '0;
                            end
                        endcase
                    end
                end
            end
            AP_ANS: begin
                next_st.ap = AP_IDLE;
                // control is plain flops untouched by power-down, so it survives it
                if (i_apb.pwrite && !st.rsp.pslverr && (i_apb.paddr == SLM_REG_CTRL)) begin
                    next_st.link_en  = i_apb.pwdata[SLM_CTRL_LINK_EN];
                    next_st.pd_req   = i_apb.pwdata[SLM_CTRL_PD];
                    next_st.fec      = i_apb.pwdata[SLM_CTRL_FEC];
                    next_st.alt_sel  = i_apb.pwdata[SLM_CTRL_ALT];
                    next_st.pair_en  = i_apb.pwdata[SLM_CTRL_PAIR +: 2];
                    next_st.mode     = i_apb.pwdata[SLM_CTRL_MODE +: 5];
                    next_st.test_req = i_apb.pwdata[SLM_CTRL_TEST +: 3];
                end
            end
        endcase

        // a new test choice applies only while the link is disabled
        if (!st.link_en) begin
            next_st.test = test_decode(st.test_req);
        end

        // lane count comes from the link mode alone, test or not
        nlanes  = lanes_for(st.mode);
        en      = SLM_LANES'((9'h1 << nlanes) - 9'h1);
        gate_hi = (st.mode == SLM_MODE_12B2) ? st.pair_en[1] : st.pair_en[0];
        en[3:0] = st.pair_en[0] ? en[3:0] : 4'h0;
        en[7:4] = gate_hi ? en[7:4] : 4'h0;
        // redundancy only when the mode fits in the lower four lanes
        alt_act = st.alt_sel && (nlanes <= 4'h4);
        if (alt_act) begin
            en = {en[3:0], 4'h0};
        end
        next_st.lane.drv_en = pd_act ? '0 : en;

        next_st.lane.octets     = octets_for(st.mode);
        next_st.lane.enc_64b66b = (st.mode != SLM_MODE_10B);
        // one sync-header bit: crc-12 or fec, there is no crc-3 code
        next_st.lane.fec        = st.fec && next_st.lane.enc_64b66b;
        next_st.lane.valid      = 1'b0;
        next_st.lane.bypass     = 1'b0;
        prbs_on = st.link_en && !pd_act && (st.test != TST_NONE) && (nlanes != 4'h0);

        // prbs: raw bits for the serializer, no encoder or scrambler after
        if (prbs_on) begin
            mask = 31'((32'h1 << slm_prbs_len(st.test)) - 32'h1);
            for (int l = 0; l < SLM_LANES; l++) begin
                s = st.prbs[l];
                // lane-unique seed; also escapes the all-zero lock-up after a length change
                if ((s & mask) == '0) begin
                    s = SLM_PRBS_SEED | 31'(l + 1);
                end
                run             = prbs_run(s, st.test);
                next_st.prbs[l] = run[70:40];
                words[l]        = run[39:0];
            end
            next_st.lane.valid  = 1'b1;
            next_st.lane.bypass = 1'b1;
        end else if (fifo_take && fifo_valid) begin
            words              = map_frame(fifo_data, st.mode);
            next_st.lane.valid = 1'b1;
            next_st.frames     = st.frames + 32'h1;
        end

        // alternate set carries what the lower lanes would
        if (next_st.lane.valid) begin
            next_st.lane.data = alt_act ? {words[3:0], words[3:0]} : words;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            st <= ST_RST;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    sequence s_pd_seen;
        st.pd_pin || st.pd_req;
    endsequence

    sequence s_pd_enter;
        !(st.pd_pin || st.pd_req) ##1 (st.pd_pin || st.pd_req);
    endsequence

    a_pd_drivers_off: assert property (s_pd_seen |=> (o_lane.drv_en == '0))
        else $error("lane drivers on during power-down");
    a_cfg_kept_pd: assert property (s_pd_enter ##0 !(st.ap == AP_ANS) |=> $stable(st.mode) && $stable(st.pair_en))
        else $error("configuration lost at power-down");
    a_alt_narrow_only: assert property ((o_lane.drv_en[7:4] != '0 && o_lane.drv_en[3:0] == '0 && $past(st.pair_en[0]))
                                        |-> (lanes_for($past(st.mode)) <= 4'h4))
        else $error("alternate lanes used with a wide mode");
    a_alt_lower_off: assert property ((st.alt_sel && lanes_for(st.mode) <= 4'h4 && $stable(st.alt_sel)
                                       && $stable(st.mode)) |=> (o_lane.drv_en[3:0] == 4'h0))
        else $error("default lanes driven while alternate set selected");
    a_test_held_link: assert property (st.link_en |=> $stable(st.test))
        else $error("test mode changed with link enabled");
    a_prbs_bypass_on: assert property (o_lane.bypass |-> o_lane.valid && ($past(st.test) != TST_NONE))
        else $error("bypass without a prbs mode");
    a_prbs7_taps: assert property ((o_lane.bypass && $past(st.test) == TST_PRBS7)
                                   |-> (o_lane.data[0][29] == (o_lane.data[0][35] ^ o_lane.data[0][36])))
        else $error("prbs7 bit is not xor of taps 6 and 7");
    a_prbs31_taps: assert property ((o_lane.bypass && $past(st.test) == TST_PRBS31)
                                    |-> (o_lane.data[1][4] == (o_lane.data[1][32] ^ o_lane.data[1][35])))
        else $error("prbs31 bit is not xor of taps 28 and 31");
    a_lane_phase_differ: assert property ((o_lane.bypass && $past(st.test) == TST_PRBS31)
                                          |-> (o_lane.data[0] != o_lane.data[1]))
        else $error("two lanes carry the same prbs phase");
    a_data_count_mode: assert property ((o_lane.valid && !o_lane.bypass)
                                        |-> (o_lane.octets == octets_for($past(st.mode))))
        else $error("octet count does not follow link mode");
    a_mode12_octet: assert property ((fifo_take && fifo_valid && st.test == TST_NONE && st.mode == SLM_MODE_8B
                                      && !(st.alt_sel))
                                     |=> (o_lane.data[1][39:32] == $past(fifo_data.smp[0][1][11:4])))
        else $error("mode 12 lane 1 is not sample A1");
    a_fec_only_66b: assert property (o_lane.fec |-> o_lane.enc_64b66b)
        else $error("fec flagged on an 8b10b mode");
endmodule // slm_lane_map

// File: tb/slm_rx_model.sv
// far-side receiver model: self-synchronising prbs checker on lane 0
`timescale 1ns/10ps
module slm_rx_model #(
    parameter int LEN = 7,
    parameter int TAP = 6
) (
    // clock and lanes
    input  wire logic               i_ref_clk,
    input  wire slm_pkg::slm_lane_t i_lane,
    // checker results
    output logic [15:0]             o_errs,
    output logic [15:0]             o_bits
);
    import slm_pkg::*;
    logic [63:0] hist;
    initial begin
        hist = '0;
        o_errs = '0;
        o_bits = '0;
    end
    // no fixed start: the first LEN bits only seed the history
    always @(posedge i_ref_clk) begin
        if (i_lane.valid && i_lane.bypass) begin
            for (int b = 39; b >= 0; b--) begin
                if (o_bits >= LEN && i_lane.data[0][b] !== (hist[TAP-1] ^ hist[LEN-1])) o_errs++;
                hist = {hist[62:0], i_lane.data[0][b]};
                if (o_bits < 16'hFFFF) o_bits++;
            end
        end
    end
endmodule // slm_rx_model

// File: tb/slm_lane_map_tb.sv
// self-checking bench for the lane mapper
`timescale 1ns/10ps
module slm_lane_map_tb;
    import slm_pkg::*;
    logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_power_down_pin = 1'b0, i_frame_valid = 1'b0;
    slm_apb_req_t i_apb = '0;
    slm_apb_rsp_t o_apb;
    slm_frame_t   i_frame;
    slm_lane_t    o_lane;
    logic         o_frame_ready;
    logic [15:0]  errs, bits;
    logic [31:0]  rd;
    logic         err;
    int           num_errors = 0, checks_done = 0;
    always #5 i_ref_clk = ~i_ref_clk;
    slm_lane_map #(.NUM_CH(2), .FIFO_DEPTH(8)) u_slm_lane_map (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_apb(i_apb), .o_apb(o_apb), .i_power_down_pin(i_power_down_pin), .i_frame(i_frame),
        .i_frame_valid(i_frame_valid), .o_frame_ready(o_frame_ready), .o_lane(o_lane));
    slm_rx_model #(.LEN(7), .TAP(6)) u_slm_rx_model (.i_ref_clk(i_ref_clk), .i_lane(o_lane),
        .o_errs(errs), .o_bits(bits));
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer; data taken at the edge that samples pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge i_ref_clk) i_apb <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
        @(posedge i_ref_clk) i_apb.penable <= 1'b1;
        do @(posedge i_ref_clk); while (o_apb.pready !== 1'b1);
        rd = o_apb.prdata;
        err = o_apb.pslverr;
        i_apb.psel <= 1'b0;
        i_apb.penable <= 1'b0;
    endtask
    // one frame in, then wait for its lane word
    task automatic send_frame();
        @(posedge i_ref_clk) i_frame_valid <= 1'b1;
        do @(posedge i_ref_clk); while (o_frame_ready !== 1'b1);
        i_frame_valid <= 1'b0;
        for (int n = 0; n < 20 && o_lane.valid !== 1'b1; n++) @(posedge i_ref_clk);
        chk(o_lane.valid === 1'b1, "no lane word");
    endtask
    initial begin
        for (int c = 0; c < SLM_CHANS; c++)
            for (int i = 0; i < SLM_SPC; i++) i_frame.smp[c][i] = {c[3:0], i[3:0], 4'hA};
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        apb(SLM_REG_CTRL, 1'b0, 32'h0);
        chk(rd === 32'h0000_0E30, "ctrl reset value");
        apb(8'h0C, 1'b0, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped read");
        // mode 12: octet per lane, lanes 4..7 carry channel B
        apb(SLM_REG_CTRL, 1'b1, 32'h0000_0C31);
        send_frame();
        for (int k = 0; k < 8; k++) chk(o_lane.data[k][39:32] === {3'h0, k[2], 2'h0, k[1:0]}, "mode12 lane");
        chk(o_lane.fec === 1'b0 && o_lane.drv_en === 8'hFF, "crc12 and drivers");
        // power-down request drops drivers, configuration survives
        apb(SLM_REG_CTRL, 1'b1, 32'h0000_0C33);
        repeat (3) @(posedge i_ref_clk);
        chk(o_lane.drv_en === 8'h00, "drivers on in power-down");
        apb(SLM_REG_CTRL, 1'b0, 32'h0);
        chk(rd === 32'h0000_0C33, "ctrl lost in power-down");
        // mode 14, two channels = four lanes, alternate set with fec
        apb(SLM_REG_CTRL, 1'b1, 32'h0000_0E3D);
        send_frame();
        chk(o_lane.drv_en[3:0] === 4'h0 && o_lane.fec === 1'b1, "alternate_lane_select or fec");
        chk(o_lane.data[5][39:16] === {12'h01A, 12'h03A}, "mode14 second lane");
        // mode 13 stride-four samples, mode 15 samples k and k+4
        apb(SLM_REG_CTRL, 1'b1, 32'h0000_0D31);
        send_frame();
        chk(o_lane.data[0] === {10'h002, 10'h012, 10'h022, 10'h032} && o_lane.enc_64b66b === 1'b0
            && o_lane.octets === 3'h5, "mode13 lane 0");
        apb(SLM_REG_CTRL, 1'b1, 32'h0000_0F31);
        send_frame();
        chk(o_lane.data[5][39:16] === {12'h11A, 12'h15A} && o_lane.octets === 3'h3, "mode15 lane 5");
        apb(SLM_REG_FRAMES, 1'b0, 32'h0);
        chk(rd === 32'h0000_0004, "frame count");
        // power-down pin passes the filter, then drivers return when it falls
        @(posedge i_ref_clk) i_power_down_pin <= 1'b1;
        repeat (6) @(posedge i_ref_clk);
        apb(SLM_REG_STATUS, 1'b0, 32'h0);
        chk(rd[0] === 1'b1 && rd[7:4] === 4'h8 && o_lane.drv_en === 8'h00, "pin power-down");
        @(posedge i_ref_clk) i_power_down_pin <= 1'b0;
        repeat (6) @(posedge i_ref_clk);
        chk(o_lane.drv_en === 8'hFF, "drivers back after pin");
        // prbs7 selected with link off, then link on
        apb(SLM_REG_CTRL, 1'b1, 32'h0000_0C30);
        apb(SLM_REG_CTRL, 1'b1, 32'h0001_0C30);
        apb(SLM_REG_CTRL, 1'b1, 32'h0001_0C31);
        repeat (40) @(posedge i_ref_clk);
        chk(o_lane.bypass === 1'b1 && o_lane.data[0] !== o_lane.data[1], "prbs bypass or phase");
        chk(errs === 16'h0 && bits > 16'h00C8, "prbs7 sequence");
        chk(o_lane.drv_en === 8'hFF, "test lanes follow mode");
        // prbs31 chosen with the link off, then link on
        apb(SLM_REG_CTRL, 1'b1, 32'h0005_0C30);
        apb(SLM_REG_CTRL, 1'b1, 32'h0005_0C31);
        repeat (4) @(posedge i_ref_clk);
        chk(o_lane.bypass === 1'b1 && o_lane.data[0] !== o_lane.data[1], "prbs31 lanes");
        chk(o_lane.data[0][4] === (o_lane.data[0][32] ^ o_lane.data[0][35]), "prbs31 taps");
        finish_test();
    end
    initial begin
        #200000;
        num_errors++;
        finish_test();
    end
endmodule // slm_lane_map_tb
